// ### core/tec_edge_sync.sv
// Purpose: Two-stage synchroniser with edge detection for pin inputs.
// Assumes: Inputs are asynchronous to i_sys_clk.
// Notes: Edges are found on the second stage only.
`timescale 1ns/1ps
`default_nettype none
module tec_edge_sync
   import tec_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [TEC_NSYNC-1:0] i_pins,
   output logic [TEC_NSYNC-1:0] o_level,
   output logic [TEC_NSYNC-1:0] o_rise,
   output logic [TEC_NSYNC-1:0] o_fall
);
   logic [TEC_NSYNC-1:0] meta;
   logic [TEC_NSYNC-1:0] sync;
   logic [TEC_NSYNC-1:0] prev;

   genvar g;
   generate
      for (g = 0; g < TEC_NSYNC; g = g + 1) begin : g_lane
         always_ff @(posedge i_sys_clk) begin
            if (!i_nrst) begin
               meta[g] <= 1'b0;
               sync[g] <= 1'b0;
               prev[g] <= 1'b0;
            end else begin
               meta[g] <= i_pins[g];
               sync[g] <= meta[g];
               prev[g] <= sync[g];
            end
         end
         assign o_level[g] = sync[g];
         assign o_rise[g] = sync[g] & ~prev[g];
         assign o_fall[g] = ~sync[g] & prev[g];
      end
   endgenerate
endmodule
`default_nettype wire

// ### core/tec_pkg.sv
// Purpose: Shared constants and types for the timer/event counter block.
// Assumes: A 32-bit Avalon-MM register port with byte addresses.
// Notes: Every register holds eight bits in the low byte lane.
package tec_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] TEC_OFS_TIMER_CONTROL = 5'h00;
   localparam logic [4:0] TEC_OFS_CNT_A_LOW = 5'h04;
   localparam logic [4:0] TEC_OFS_CNT_A_HIGH = 5'h08;
   localparam logic [4:0] TEC_OFS_CNT_B_LOW = 5'h0C;
   localparam logic [4:0] TEC_OFS_CNT_B_HIGH = 5'h10;
   localparam logic [4:0] TEC_OFS_CONV_CONFIG = 5'h14;
   localparam logic [4:0] TEC_OFS_IRQ_FLAGS = 5'h18;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int TEC_CTL_MODE_LSB = 5;
   localparam int TEC_CTL_RUN_BIT = 4;
   localparam int TEC_CTL_EDGE_BIT = 3;
   localparam int TEC_CFG_EXT_SEL_BIT = 7;
   localparam int TEC_CFG_BCLK_SEL_BIT = 6;
   localparam int TEC_CFG_LSO_EN_BIT = 5;
   localparam int TEC_CFG_RPATH_BIT = 2;
   localparam int TEC_CFG_CONV_BIT = 1;
   localparam int TEC_CFG_OVSRC_BIT = 0;
   localparam int TEC_FLG_TIMER_BIT = 0;
   localparam int TEC_FLG_CONV_BIT = 1;

   // ----------------------------------------------------------------
   // Synchronised input lanes
   // ----------------------------------------------------------------
   localparam int TEC_NSYNC = 4;
   localparam int TEC_IN_EXT0 = 0;
   localparam int TEC_IN_EXT1 = 1;
   localparam int TEC_IN_RTOF = 2;
   localparam int TEC_IN_LSO = 3;

   // ----------------------------------------------------------------
   // Modes, values and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] TEC_MODE_UNUSED = 2'h0;
   localparam logic [1:0] TEC_MODE_EVENT = 2'h1;
   localparam logic [1:0] TEC_MODE_TIMER = 2'h2;
   localparam logic [1:0] TEC_MODE_PULSE = 2'h3;
   localparam logic [15:0] TEC_CNT_MAX = 16'hFFFF;
   localparam logic [15:0] TEC_CNT_RST = 16'h0000;
   localparam logic [7:0] TEC_BYTE_RST = 8'h00;
   localparam logic TEC_EDGE_RST = 1'b1;

   typedef struct packed {
      logic [1:0] mode;
      logic run;
      logic edge_sel;
   } tec_ctrl_t;

   typedef struct packed {
      logic ext_sel;
      logic bclk_sel;
      logic lso_en;
      logic rpath_sel;
      logic conv_mode;
      logic ovsrc_b;
   } tec_cfg_t;

   typedef enum logic [1:0] {
      TEC_PW_IDLE = 2'b00,
      TEC_PW_WAIT = 2'b01,
      TEC_PW_MEAS = 2'b11
   } tec_pw_state_t;

endpackage

// ### core/tec_top.sv
// Purpose: 16-bit timer/event counter with R-to-F converter mode.
// Assumes: Avalon-MM slave, one wait state per access, 10 MHz clock.
// Notes: Registers are eight bits wide in the low byte lane.
//
// How it works
// - Mode field 01 counts pin events, 10 counts clock, 11 measures pulses.
// - Control bit 4 is the run bit; 0 stops, 1 counts.
// - Event mode counts rising edges with edge select 0, falling with 1.
// - Pulse mode: select 0 runs falling to rising, 1 rising to falling.
// - Normal mode: A pair is the live count, B pair the reload.
// - Reload low write fills buffer; high write loads all sixteen bits.
// - Counter high read latches low byte; low read returns the buffer.
// - Reload write while stopped also loads the counter.
// - Counting is held off while the counter high byte is read.
// - Counter wraps past FFFF by reloading and raising the timer flag.
// - Pulse mode counts one pulse, clears run, keeps the result.
// - Pulse mode overflow reloads and flags like the other modes.
// - Hardware clears run at the end of a pulse measurement and on the chosen converter overflow.
// - Converter mode turns the pairs into two separate counters A and B.
// - Counter B counts the R-to-F output or low-speed oscillator.
// - Overflow source bit picks which counter sets the converter flag.
// - Run starts both; chosen overflow flags, stops both, clears run.
// - Converter low writes buffer; high write loads; high read latches.
// - Converter counters never reload; B keeps its value at the end.
// - Resistor path bit picks reference (0) or sensor (1) network.
`timescale 1ns/1ps
`default_nettype none
module tec_top
   import tec_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_ext_count_input_0,
   input wire logic i_ext_count_input_1,
   input wire logic i_rtof_osc,
   input wire logic i_low_speed_internal_osc,
   output logic o_resistor_path_select,
   output logic o_low_speed_osc_enable,
   output logic o_timer_irq_flag,
   output logic o_converter_irq_flag
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   tec_ctrl_t ctrl;
   tec_cfg_t cfg;
   tec_pw_state_t pw_state;
   tec_pw_state_t next_pw_state;
   logic [15:0] cnt_a;
   logic [15:0] cnt_b;
   logic [7:0] lo_buf;
   logic flag_timer;
   logic flag_conv;
   logic done;
   logic req;
   logic acc_wr;
   logic acc_rd;
   logic [7:0] wbyte;
   logic [TEC_NSYNC-1:0] pin_level;
   logic [TEC_NSYNC-1:0] pin_rise;
   logic [TEC_NSYNC-1:0] pin_fall;
   logic ext_rise;
   logic ext_fall;
   logic hold_a;
   logic hold_b;
   logic tick_a;
   logic tick_b;
   logic ovf_a;
   logic ovf_b;
   logic conv_stop;
   logic pw_end;
   logic wr_ctrl;
   logic [31:0] next_readdata;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   tec_edge_sync u_sync (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_pins({i_low_speed_internal_osc, i_rtof_osc,
               i_ext_count_input_1, i_ext_count_input_0}),
      .o_level(pin_level),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   assign ext_rise = cfg.ext_sel ? pin_rise[TEC_IN_EXT1] :
                                   pin_rise[TEC_IN_EXT0];
   assign ext_fall = cfg.ext_sel ? pin_fall[TEC_IN_EXT1] :
                                   pin_fall[TEC_IN_EXT0];

   // ----------------------------------------------------------------
   // Avalon-MM slave handshake
   // ----------------------------------------------------------------
   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~done;
   assign acc_wr = i_avs_write & done & i_avs_byteenable[0];
   assign acc_rd = i_avs_read & done;
   assign wbyte = i_avs_writedata[7:0];
   assign wr_ctrl = acc_wr && (i_avs_address == TEC_OFS_TIMER_CONTROL);

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         done <= 1'b0;
      end else begin
         done <= req & ~done;
      end
   end

   always_comb begin
      next_readdata = 32'h0000_0000;
      case (i_avs_address)
         TEC_OFS_TIMER_CONTROL: begin
            next_readdata[TEC_CTL_MODE_LSB+1:TEC_CTL_MODE_LSB] = ctrl.mode;
            next_readdata[TEC_CTL_RUN_BIT] = ctrl.run;
            next_readdata[TEC_CTL_EDGE_BIT] = ctrl.edge_sel;
         end
         TEC_OFS_CNT_A_LOW: next_readdata[7:0] = lo_buf;
         TEC_OFS_CNT_A_HIGH: next_readdata[7:0] = cnt_a[15:8];
         TEC_OFS_CNT_B_LOW: next_readdata[7:0] = lo_buf;
         TEC_OFS_CNT_B_HIGH: next_readdata[7:0] = cnt_b[15:8];
         TEC_OFS_CONV_CONFIG: begin
            next_readdata[TEC_CFG_EXT_SEL_BIT] = cfg.ext_sel;
            next_readdata[TEC_CFG_BCLK_SEL_BIT] = cfg.bclk_sel;
            next_readdata[TEC_CFG_LSO_EN_BIT] = cfg.lso_en;
            next_readdata[TEC_CFG_RPATH_BIT] = cfg.rpath_sel;
            next_readdata[TEC_CFG_CONV_BIT] = cfg.conv_mode;
            next_readdata[TEC_CFG_OVSRC_BIT] = cfg.ovsrc_b;
         end
         TEC_OFS_IRQ_FLAGS: begin
            next_readdata[TEC_FLG_TIMER_BIT] = flag_timer;
            next_readdata[TEC_FLG_CONV_BIT] = flag_conv;
         end
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_avs_readdata <= 32'h0000_0000;
      end else if (i_avs_read && !done) begin
         o_avs_readdata <= next_readdata;
      end
   end

   // ----------------------------------------------------------------
   // Configuration register
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         cfg <= '0;
      end else if (acc_wr && i_avs_address == TEC_OFS_CONV_CONFIG) begin
         cfg.ext_sel <= wbyte[TEC_CFG_EXT_SEL_BIT];
         cfg.bclk_sel <= wbyte[TEC_CFG_BCLK_SEL_BIT];
         cfg.lso_en <= wbyte[TEC_CFG_LSO_EN_BIT];
         cfg.rpath_sel <= wbyte[TEC_CFG_RPATH_BIT];
         cfg.conv_mode <= wbyte[TEC_CFG_CONV_BIT];
         cfg.ovsrc_b <= wbyte[TEC_CFG_OVSRC_BIT];
      end
   end

   assign o_resistor_path_select = cfg.rpath_sel;
   assign o_low_speed_osc_enable = cfg.lso_en;

   // ----------------------------------------------------------------
   // Count qualification
   // ----------------------------------------------------------------
   // Holds both pending and accepted cycles of a high byte read.
   assign hold_a = i_avs_read &&
                   (i_avs_address == TEC_OFS_CNT_A_HIGH);
   assign hold_b = i_avs_read && cfg.conv_mode &&
                   (i_avs_address == TEC_OFS_CNT_B_HIGH);

   always_comb begin
      tick_a = 1'b0;
      if (ctrl.run && !hold_a) begin
         case (ctrl.mode)
            TEC_MODE_EVENT: tick_a = ctrl.edge_sel ? ext_fall :
                                                    ext_rise;
            TEC_MODE_TIMER: tick_a = 1'b1;
            TEC_MODE_PULSE: tick_a = (pw_state == TEC_PW_MEAS) &&
                                     !pw_end;
            default: tick_a = 1'b0;
         endcase
      end
   end

   assign tick_b = cfg.conv_mode && ctrl.run && !hold_b &&
                   (cfg.bclk_sel ? pin_rise[TEC_IN_RTOF] :
                                   pin_rise[TEC_IN_LSO]);
   assign ovf_a = tick_a && (cnt_a == TEC_CNT_MAX);
   assign ovf_b = tick_b && (cnt_b == TEC_CNT_MAX);
   assign conv_stop = cfg.conv_mode &&
                      (cfg.ovsrc_b ? ovf_b : ovf_a);

   // ----------------------------------------------------------------
   // Pulse width measurement sequencer
   // ----------------------------------------------------------------
   assign pw_end = (pw_state == TEC_PW_MEAS) &&
                   (ctrl.edge_sel ? ext_fall : ext_rise);

   always_comb begin
      next_pw_state = pw_state;
      case (pw_state)
         TEC_PW_IDLE: begin
            if (ctrl.run && ctrl.mode == TEC_MODE_PULSE && !cfg.conv_mode)
               next_pw_state = TEC_PW_WAIT;
         end
         TEC_PW_WAIT: begin
            if (!ctrl.run || ctrl.mode != TEC_MODE_PULSE)
               next_pw_state = TEC_PW_IDLE;
            else if (ctrl.edge_sel ? ext_rise : ext_fall)
               next_pw_state = TEC_PW_MEAS;
         end
         TEC_PW_MEAS: begin
            if (!ctrl.run || ctrl.mode != TEC_MODE_PULSE || pw_end)
               next_pw_state = TEC_PW_IDLE;
         end
         default: next_pw_state = TEC_PW_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         pw_state <= TEC_PW_IDLE;
      end else begin
         pw_state <= next_pw_state;
      end
   end

   // ----------------------------------------------------------------
   // Control register and run bit
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         ctrl.mode <= TEC_MODE_UNUSED;
         ctrl.edge_sel <= TEC_EDGE_RST;
      end else if (wr_ctrl) begin
         ctrl.mode <= wbyte[TEC_CTL_MODE_LSB+1:TEC_CTL_MODE_LSB];
         ctrl.edge_sel <= wbyte[TEC_CTL_EDGE_BIT];
      end
   end

   // A software write wins over a hardware clear in the same cycle.
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         ctrl.run <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl.run <= wbyte[TEC_CTL_RUN_BIT];
      end else if (pw_end && !cfg.conv_mode) begin
         ctrl.run <= 1'b0;
      end else if (conv_stop) begin
         ctrl.run <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Low byte buffer
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         lo_buf <= TEC_BYTE_RST;
      end else if (acc_wr && (i_avs_address == TEC_OFS_CNT_A_LOW ||
                              i_avs_address == TEC_OFS_CNT_B_LOW)) begin
         lo_buf <= wbyte;
      end else if (acc_rd && i_avs_address == TEC_OFS_CNT_A_HIGH) begin
         lo_buf <= cnt_a[7:0];
      end else if (acc_rd && i_avs_address == TEC_OFS_CNT_B_HIGH) begin
         lo_buf <= cnt_b[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Counter A
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         cnt_a <= TEC_CNT_RST;
      end else if (acc_wr && i_avs_address == TEC_OFS_CNT_A_HIGH) begin
         cnt_a <= {wbyte, lo_buf};
      end else if (acc_wr && i_avs_address == TEC_OFS_CNT_B_HIGH &&
                   !cfg.conv_mode && !ctrl.run) begin
         cnt_a <= {wbyte, lo_buf};
      end else if (ovf_a && !cfg.conv_mode) begin
         cnt_a <= cnt_b;
      end else if (tick_a) begin
         cnt_a <= cnt_a + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Counter B, also the reload value outside converter mode
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         cnt_b <= TEC_CNT_RST;
      end else if (acc_wr && i_avs_address == TEC_OFS_CNT_B_HIGH) begin
         cnt_b <= {wbyte, lo_buf};
      end else if (tick_b) begin
         cnt_b <= cnt_b + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Request flags
   // ----------------------------------------------------------------
   // Flags clear on writing one; a same-cycle set wins.
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         flag_timer <= 1'b0;
      end else if (ovf_a && !cfg.conv_mode) begin
         flag_timer <= 1'b1;
      end else if (acc_wr && i_avs_address == TEC_OFS_IRQ_FLAGS &&
                   wbyte[TEC_FLG_TIMER_BIT]) begin
         flag_timer <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         flag_conv <= 1'b0;
      end else if (conv_stop) begin
         flag_conv <= 1'b1;
      end else if (acc_wr && i_avs_address == TEC_OFS_IRQ_FLAGS &&
                   wbyte[TEC_FLG_CONV_BIT]) begin
         flag_conv <= 1'b0;
      end
   end

   assign o_timer_irq_flag = flag_timer;
   assign o_converter_irq_flag = flag_conv;

endmodule
`default_nettype wire

// ### dv/tec_monitor.sv
// Purpose: Port checker for the timer/event counter block.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Bound to tec_top below the module.
`timescale 1ns/1ps
`default_nettype none
module tec_monitor
   import tec_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic i_ext_count_input_0,
   input wire logic i_ext_count_input_1,
   input wire logic i_rtof_osc,
   input wire logic i_low_speed_internal_osc,
   input wire logic o_resistor_path_select,
   input wire logic o_low_speed_osc_enable,
   input wire logic o_timer_irq_flag,
   input wire logic o_converter_irq_flag
);
   // ----
   // Helper state
   // ----
   logic wacc;
   logic conv_sh;
   assign wacc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         conv_sh <= 1'b0;
      end else if (wacc && i_avs_address == TEC_OFS_CONV_CONFIG) begin
         conv_sh <= i_avs_writedata[TEC_CFG_CONV_BIT];
      end
   end
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_nrst);
   // ----
   // Assertions
   // ----
   one_wait_a: assert property (
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus wait longer than one cycle");
   idle_wait_a: assert property (
      !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
      else $error("waitrequest without request");
   rd_lane_a: assert property (
      i_avs_read && !o_avs_waitrequest && i_avs_address == 5'h00
      |-> o_avs_readdata[31:8] == 24'h0 && o_avs_readdata[2:0] == 3'h0)
      else $error("unused control bits not zero");
   rpath_a: assert property (
      wacc && i_avs_address == TEC_OFS_CONV_CONFIG |=> o_resistor_path_select
      == $past(i_avs_writedata[TEC_CFG_RPATH_BIT]))
      else $error("resistor path select wrong");
   lso_a: assert property (
      wacc && i_avs_address == TEC_OFS_CONV_CONFIG |=> o_low_speed_osc_enable
      == $past(i_avs_writedata[TEC_CFG_LSO_EN_BIT]))
      else $error("oscillator enable wrong");
   tflag_hold_a: assert property (
      o_timer_irq_flag && !(wacc && i_avs_address == TEC_OFS_IRQ_FLAGS
      && i_avs_writedata[0]) |=> o_timer_irq_flag)
      else $error("timer flag lost");
   cflag_hold_a: assert property (
      o_converter_irq_flag && !(wacc && i_avs_address == TEC_OFS_IRQ_FLAGS
      && i_avs_writedata[1]) |=> o_converter_irq_flag)
      else $error("converter flag lost");
   tflag_mode_a: assert property (
      $rose(o_timer_irq_flag) |-> !$past(conv_sh))
      else $error("timer flag in converter mode");
   cflag_mode_a: assert property (
      $rose(o_converter_irq_flag) |-> $past(conv_sh))
      else $error("converter flag in normal mode");
   cover property ($rose(o_timer_irq_flag));
   cover property ($rose(o_converter_irq_flag));
   cover property ($rose(o_resistor_path_select));
endmodule
bind tec_top tec_monitor u_mon (.*);
`default_nettype wire

// ### dv/tec_pin_model.sv
// Purpose: Pins and oscillators outside the counter block.
// Assumes: Oscillators hold their level while disabled.
// Notes: Count pins change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module tec_pin_model (
   input wire logic i_sys_clk,
   input wire logic i_rtof_en,
   input wire logic i_lso_en,
   output logic o_ext0,
   output logic o_ext1,
   output logic o_rtof,
   output logic o_lso
);
   initial begin
      o_ext0 = 1'b0;
      o_ext1 = 1'b0;
      o_rtof = 1'b0;
      o_lso = 1'b0;
   end
   always #170 o_rtof = i_rtof_en ? !o_rtof : o_rtof;
   always #3906 o_lso = i_lso_en ? !o_lso : o_lso;
   task automatic set_pin(input int idx, input logic v);
      @(posedge i_sys_clk);
      if (idx == 0) begin
         o_ext0 <= v;
      end else begin
         o_ext1 <= v;
      end
   endtask
endmodule
`default_nettype wire

// ### dv/tec_top_bench.sv
// Purpose: Self-checking bench for the timer/event counter block.
// Assumes: Avalon-MM register port, one wait state.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/1ps
`default_nettype none
module tec_top_bench;
   import tec_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] av_addr = 5'h00;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wdata = 32'h0;
   logic [31:0] av_rdata;
   logic av_wait;
   logic ext0, ext1, rtof, lso, rpath, lso_en, tflag, cflag;
   logic rtof_en = 1'b0;
   int errors = 0;
   int total_checks = 0;
   always #50 sys_clk = !sys_clk;
   tec_top uut (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_avs_address(av_addr),
      .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_byteenable(4'hF),
      .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata),
      .o_avs_waitrequest(av_wait), .i_ext_count_input_0(ext0),
      .i_ext_count_input_1(ext1), .i_rtof_osc(rtof),
      .i_low_speed_internal_osc(lso), .o_resistor_path_select(rpath),
      .o_low_speed_osc_enable(lso_en), .o_timer_irq_flag(tflag),
      .o_converter_irq_flag(cflag));
   tec_pin_model pins (.i_sys_clk(sys_clk), .i_rtof_en(rtof_en),
      .i_lso_en(lso_en), .o_ext0(ext0), .o_ext1(ext1), .o_rtof(rtof),
      .o_lso(lso));
   // ----
   // Shared tasks
   // ----
   function automatic logic [7:0] ctl(input logic [1:0] m, input logic r,
                                      input logic e);
      return {1'b0, m, r, e, 3'h0};
   endfunction
   task automatic final_report;
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      av_rd <= !w;
      av_wr <= w;
      av_addr <= a;
      av_wdata <= {24'h0, d};
      n = 0;
      @(posedge sys_clk);
      while (av_wait !== 1'b0) begin
         n++;
         if (n > 20) begin
            errors++;
            final_report();
         end
         @(posedge sys_clk);
      end
      q = av_rdata[7:0];
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] q);
      bus(1'b0, a, 8'h00, q);
   endtask
   task automatic wr16(input logic [4:0] hi, lo, input logic [15:0] v);
      wr(lo, v[7:0]);
      wr(hi, v[15:8]);
   endtask
   task automatic rd16(input logic [4:0] hi, lo, output logic [15:0] v);
      rd(hi, v[15:8]);
      rd(lo, v[7:0]);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic waitf(input logic c, input int lim);
      for (int n = 0; (c ? cflag : tflag) !== 1'b1; n++) begin
         if (n >= lim) begin
            errors++;
            final_report();
         end
         @(posedge sys_clk);
      end
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_regs;
      logic [7:0] q;
      logic [15:0] v;
      rd(TEC_OFS_TIMER_CONTROL, q);
      check("ctl_reset", {8'h0, q}, 16'h0008);
      wr(TEC_OFS_TIMER_CONTROL, 8'hFF);
      rd(TEC_OFS_TIMER_CONTROL, q);
      check("ctl_bits", {8'h0, q}, 16'h0078);
      wr(TEC_OFS_TIMER_CONTROL, 8'h00);
      rd(5'h1C, q);
      check("unmapped", {8'h0, q}, 16'h0000);
      wr16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, 16'h1234);
      rd16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, v);
      check("cnt_load", v, 16'h1234);
      wr(TEC_OFS_CNT_B_LOW, 8'h56);
      rd16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, v);
      check("low_buf", v, 16'h1234);
      wr(TEC_OFS_CNT_B_LOW, 8'h77);
      rd(TEC_OFS_CNT_A_LOW, q);
      check("low_read", {8'h0, q}, 16'h0077);
   endtask
   task automatic t_event;
      logic [15:0] v;
      for (int e = 0; e < 2; e++) begin
         wr16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, 16'h0000);
         wr(TEC_OFS_TIMER_CONTROL, ctl(TEC_MODE_EVENT, 1'b1, e[0]));
         pins.set_pin(0, 1'b1);
         idle(6);
         rd16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, v);
         check("evt_rise", v, {15'h0, !e[0]});
         pins.set_pin(0, 1'b0);
         idle(6);
         rd16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, v);
         check("evt_fall", v, 16'h0001);
         wr(TEC_OFS_TIMER_CONTROL, ctl(TEC_MODE_EVENT, 1'b0, e[0]));
      end
   endtask
   task automatic t_pulse;
      logic [15:0] v;
      logic [15:0] w;
      logic [7:0] q;
      wr16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, 16'h0000);
      wr(TEC_OFS_TIMER_CONTROL, ctl(TEC_MODE_PULSE, 1'b1, 1'b1));
      pins.set_pin(0, 1'b1);
      idle(19);
      pins.set_pin(0, 1'b0);
      idle(8);
      rd(TEC_OFS_TIMER_CONTROL, q);
      check("pw_run", {15'h0, q[TEC_CTL_RUN_BIT]}, 16'h0000);
      rd16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, v);
      check("pw_width", v, 16'h13);
      pins.set_pin(0, 1'b1);
      idle(9);
      pins.set_pin(0, 1'b0);
      idle(8);
      rd16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, w);
      check("pw_hold", w, v);
   endtask
   task automatic t_timer;
      logic [15:0] v;
      logic [7:0] q;
      wr16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, 16'hFF00);
      wr(TEC_OFS_TIMER_CONTROL, ctl(TEC_MODE_TIMER, 1'b1, 1'b0));
      wr16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, 16'h8000);
      waitf(1'b0, 400);
      rd(TEC_OFS_TIMER_CONTROL, q);
      check("tmr_run", {15'h0, q[TEC_CTL_RUN_BIT]}, 16'h0001);
      wr(TEC_OFS_TIMER_CONTROL, ctl(TEC_MODE_TIMER, 1'b0, 1'b0));
      rd16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, v);
      check("tmr_reload", {8'h0, v[15:8]}, 16'h0080);
      wr(TEC_OFS_IRQ_FLAGS, 8'h01);
      check("tflag_clr", {15'h0, tflag}, 16'h0000);
   endtask
   task automatic t_conv;
      logic [15:0] v;
      logic [15:0] w;
      logic [7:0] q;
      wr(TEC_OFS_CONV_CONFIG, 8'h46);
      check("rpath", {15'h0, rpath}, 16'h0001);
      wr16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, 16'hFF00);
      wr16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, 16'h0000);
      rtof_en <= 1'b1;
      wr(TEC_OFS_TIMER_CONTROL, ctl(TEC_MODE_TIMER, 1'b1, 1'b0));
      waitf(1'b1, 400);
      rtof_en <= 1'b0;
      rd(TEC_OFS_TIMER_CONTROL, q);
      check("cv_run", {15'h0, q[TEC_CTL_RUN_BIT]}, 16'h0000);
      rd16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, v);
      check("cv_a_wrap", v, 16'h0000);
      rd16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, v);
      rd16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, w);
      check("cv_b_hold", w, v);
      check("cv_b_cnt", {15'h0, v != 16'h0}, 16'h0001);
      wr(TEC_OFS_IRQ_FLAGS, 8'h02);
      wr(TEC_OFS_CONV_CONFIG, 8'h23);
      check("lso_en", {15'h0, lso_en}, 16'h0001);
      wr16(TEC_OFS_CNT_A_HIGH, TEC_OFS_CNT_A_LOW, 16'h0000);
      wr16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, 16'hFFF0);
      wr(TEC_OFS_TIMER_CONTROL, ctl(TEC_MODE_TIMER, 1'b1, 1'b0));
      waitf(1'b1, 2000);
      rd16(TEC_OFS_CNT_B_HIGH, TEC_OFS_CNT_B_LOW, v);
      check("cv_b_wrap", v, 16'h0000);
      check("cv_tflag", {15'h0, tflag}, 16'h0000);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_event();
      t_pulse();
      t_timer();
      t_conv();
      final_report();
   end
endmodule
`default_nettype wire
